// *** core/dcc_pkg.sv ***
// constants and types shared by the dual comparator control block
package dcc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] DCC_OFS_MIS    = 12'h000;
  localparam logic [11:0] DCC_OFS_RIS    = 12'h004;
  localparam logic [11:0] DCC_OFS_INTEN  = 12'h008;
  localparam logic [11:0] DCC_OFS_REFCTL = 12'h010;
  localparam logic [11:0] DCC_OFS_STAT0  = 12'h020;
  localparam logic [11:0] DCC_OFS_CTL0   = 12'h024;
  localparam logic [11:0] DCC_OFS_STAT1  = 12'h040;
  localparam logic [11:0] DCC_OFS_CTL1   = 12'h044;

  // ---------------------------------------------------------------
  // comparator control fields
  // ---------------------------------------------------------------
  localparam int DCC_CTL_W       = 12;
  localparam int DCC_CTL_INV     = 1;
  localparam int DCC_CTL_ISEN    = 2;
  localparam int DCC_CTL_ISLVAL  = 4;
  localparam int DCC_CTL_TSEN    = 5;
  localparam int DCC_CTL_TSLVAL  = 7;
  localparam int DCC_CTL_SRC     = 9;
  localparam int DCC_CTL_TOEN    = 11;
  localparam int DCC_STAT_OUTVAL = 1;

  // ---------------------------------------------------------------
  // reference control fields
  // ---------------------------------------------------------------
  localparam int DCC_REF_W   = 10;
  localparam int DCC_REF_TAP = 0;
  localparam int DCC_REF_RNG = 8;
  localparam int DCC_REF_EN  = 9;

  // ---------------------------------------------------------------
  // reset values and ladder figures
  // ---------------------------------------------------------------
  localparam logic [11:0] DCC_CTL_RST   = 12'h000;
  localparam logic [9:0]  DCC_REF_RST   = 10'h000;
  localparam logic [1:0]  DCC_EVT_RST   = 2'h0;
  localparam logic [4:0]  DCC_DIV_HIGH  = 5'h17;
  localparam logic [4:0]  DCC_DIV_LOW   = 5'h1f;
  localparam logic [4:0]  DCC_TAP_SHIFT = 5'h08;

  // positive input routing, in field-code order
  typedef enum logic [1:0] {
    DCC_SRC_OWN_PIN,
    DCC_SRC_ZERO_PIN,
    DCC_SRC_INT_REF,
    DCC_SRC_RESERVED
  } dcc_src_t;

  // event sense, in field-code order
  typedef enum logic [1:0] {
    DCC_SENSE_LEVEL,
    DCC_SENSE_FALL,
    DCC_SENSE_RISE,
    DCC_SENSE_BOTH
  } dcc_sense_t;

endpackage : dcc_pkg

// *** core/dcc_event_unit.sv ***
// result synchroniser and independent interrupt / trigger event detect
`timescale 1ns/1ns
module dcc_event_unit
  import dcc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       result_async,
  input  wire logic       invert,
  input  wire logic [1:0] int_sense,
  input  wire logic       int_level,
  input  wire logic [1:0] trig_sense,
  input  wire logic       trig_level,
  output logic            value,
  output logic            int_event,
  output logic            trig_event
);

  logic sync_a;
  logic sync_b;
  logic prev;

  function automatic logic sense_hit(input logic [1:0] sense,
                                     input logic       lvl,
                                     input logic       cur,
                                     input logic       old);
    unique case (dcc_sense_t'(sense))
      DCC_SENSE_LEVEL: sense_hit = (cur == lvl);
      DCC_SENSE_FALL:  sense_hit = old & ~cur;
      DCC_SENSE_RISE:  sense_hit = ~old & cur;
      DCC_SENSE_BOTH:  sense_hit = old ^ cur;
    endcase
  endfunction : sense_hit

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= result_async;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value <= 1'b0;
      prev  <= 1'b0;
    end else begin
      value <= sync_b ^ invert;
      prev  <= value;
    end
  end

  assign int_event  = sense_hit(int_sense, int_level, value, prev);
  assign trig_event = sense_hit(trig_sense, trig_level, value, prev);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_result_follow: assert property (
    !$past(invert) |-> value == $past(result_async, 3))
    else $error("result does not follow synchronised input");
  a_rise_pulse: assert property (
    (int_sense == 2'h2) && int_event |-> value && !prev ##1 !int_event)
    else $error("rising interrupt event not a single-cycle edge");
  a_trig_fall: assert property (
    (trig_sense == 2'h1) && $fell(value) && $stable(trig_sense) |-> trig_event)
    else $error("falling trigger edge missed");

endmodule : dcc_event_unit

// *** core/dcc_core.sv ***
// dual comparator control: apb registers, events, interrupt and reference
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
module dcc_core
  import dcc_pkg::*;
#(
  parameter int NUM_CMP = 2
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic [1:0]  comparison_result,
  output logic [1:0]       pos_source_select_zero,
  output logic [1:0]       pos_source_select_one,
  output logic             ladder_enable,
  output logic             ladder_range,
  output logic [3:0]       ladder_tap,
  output logic [4:0]       ref_numerator,
  output logic [4:0]       ref_denominator,
  output logic             cmp_zero_out_pin,
  output logic [1:0]       adc_trigger,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DCC_CTL_W-1:0] ctl [NUM_CMP];
  logic [DCC_REF_W-1:0] refctl;
  logic [1:0]           inten;
  logic [1:0]           raw;
  logic [1:0]           value;
  logic [1:0]           int_ev;
  logic [1:0]           trig_ev;
  logic                 setup;
  logic                 access;
  logic                 hit;
  logic                 wr;
  logic [1:0]           clr;
  logic [31:0]          next_prdata;
  logic [4:0]           next_numerator;

  // ---------------------------------------------------------------
  // per-comparator event units
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    dcc_event_unit u_evt (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .result_async (comparison_result[i]),
      .invert       (ctl[i][DCC_CTL_INV]),
      .int_sense    (ctl[i][DCC_CTL_ISEN+:2]),
      .int_level    (ctl[i][DCC_CTL_ISLVAL]),
      .trig_sense   (ctl[i][DCC_CTL_TSEN+:2]),
      .trig_level   (ctl[i][DCC_CTL_TSLVAL]),
      .value        (value[i]),
      .int_event    (int_ev[i]),
      .trig_event   (trig_ev[i])
    );
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // zero wait states: data is prepared in the setup cycle
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      DCC_OFS_MIS, DCC_OFS_RIS, DCC_OFS_INTEN, DCC_OFS_REFCTL,
      DCC_OFS_STAT0, DCC_OFS_CTL0, DCC_OFS_STAT1, DCC_OFS_CTL1:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error, writes dropped
  assign pslverr = access & ~hit;
  assign wr      = access & pwrite & hit;

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      DCC_OFS_MIS:    next_prdata[1:0] = raw & inten;
      DCC_OFS_RIS:    next_prdata[1:0] = raw;
      DCC_OFS_INTEN:  next_prdata[1:0] = inten;
      DCC_OFS_REFCTL: next_prdata[DCC_REF_W-1:0] = refctl;
      DCC_OFS_STAT0:  next_prdata[DCC_STAT_OUTVAL] = value[0];
      DCC_OFS_CTL0:   next_prdata[DCC_CTL_W-1:0] = ctl[0];
      DCC_OFS_STAT1:  next_prdata[DCC_STAT_OUTVAL] = value[1];
      DCC_OFS_CTL1:   next_prdata[DCC_CTL_W-1:0] = ctl[1];
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // source field holds whatever software wrote; route maps the reserved code to the own pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl[0] <= DCC_CTL_RST;
      ctl[1] <= DCC_CTL_RST;
    end else if (wr && paddr == DCC_OFS_CTL0) begin
      ctl[0] <= pwdata[DCC_CTL_W-1:0];
    end else if (wr && paddr == DCC_OFS_CTL1) begin
      ctl[1] <= pwdata[DCC_CTL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      refctl <= DCC_REF_RST;
    end else if (wr && paddr == DCC_OFS_REFCTL) begin
      refctl <= pwdata[DCC_REF_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inten <= DCC_EVT_RST;
    end else if (wr && paddr == DCC_OFS_INTEN) begin
      inten <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // event status and interrupt
  // ---------------------------------------------------------------
  // write one clears, write zero ignored
  assign clr = (wr && paddr == DCC_OFS_MIS) ? pwdata[1:0] : 2'h0;

  // raw sets regardless of enable; a new event beats a clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw <= DCC_EVT_RST;
    end else begin
      raw <= (raw & ~clr) | int_ev;
    end
  end

  assign irq = |(raw & inten);

  // ---------------------------------------------------------------
  // converter triggers and pin output
  // ---------------------------------------------------------------
  // trigger path ignores interrupt sense
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_trigger <= 2'h0;
    end else begin
      adc_trigger <= trig_ev;
    end
  end

  // only comparator zero reaches a pin
  // the gpio mux outside picks this up only once selected
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_zero_out_pin <= 1'b0;
    end else begin
      cmp_zero_out_pin <= value[0] & ctl[0][DCC_CTL_TOEN];
    end
  end

  // ---------------------------------------------------------------
  // analog controls
  // ---------------------------------------------------------------
  function automatic logic [1:0] route(input logic [1:0] code);
    // reserved code falls back to the own pin so the input never floats
    route = (dcc_src_t'(code) == DCC_SRC_RESERVED) ? 2'(DCC_SRC_OWN_PIN) : code;
  endfunction : route

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_source_select_zero <= 2'h0;
      pos_source_select_one  <= 2'h0;
    end else begin
      pos_source_select_zero <= route(ctl[0][DCC_CTL_SRC+:2]);
      pos_source_select_one  <= route(ctl[1][DCC_CTL_SRC+:2]);
    end
  end

  always_comb begin
    next_numerator = 5'h00;
    if (refctl[DCC_REF_EN]) begin
      next_numerator = refctl[DCC_REF_RNG] ? {1'b0, refctl[DCC_REF_TAP+:4]}
                                           : 5'({1'b0, refctl[DCC_REF_TAP+:4]} + DCC_TAP_SHIFT);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ladder_enable   <= 1'b0;
      ladder_range    <= 1'b0;
      ladder_tap      <= 4'h0;
      ref_numerator   <= 5'h00;
      ref_denominator <= DCC_DIV_LOW;
    end else begin
      ladder_enable   <= refctl[DCC_REF_EN];
      ladder_range    <= refctl[DCC_REF_RNG];
      ladder_tap      <= refctl[DCC_REF_TAP+:4];
      ref_numerator   <= next_numerator;
      ref_denominator <= refctl[DCC_REF_RNG] ? DCC_DIV_HIGH : DCC_DIV_LOW;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_wr_ref_en;
    wr && paddr == DCC_OFS_REFCTL;
  endsequence

  sequence s_wr_ctl0;
    wr && paddr == DCC_OFS_CTL0;
  endsequence

  sequence s_clr0;
    wr && paddr == DCC_OFS_MIS && pwdata[0] && !int_ev[0];
  endsequence

  a_ladder_ground: assert property (
    !ladder_enable |-> ref_numerator == 5'h00)
    else $error("reference not ground with ladder off");

  a_ladder_ratio: assert property (
    ladder_enable |-> (ladder_range ? (ref_numerator == {1'b0, ladder_tap} && ref_denominator == 5'h17)
                                    : (ref_numerator == 5'({1'b0, ladder_tap} + 5'h08)
                                       && ref_denominator == 5'h1f)))
    else $error("reference ratio wrong");

  a_ladder_power: assert property (
    s_wr_ref_en ##2 1'b1 |-> ladder_enable == $past(pwdata[9], 2))
    else $error("ladder enable not taken from bit nine");

  a_source_route: assert property (
    s_wr_ctl0 ##1 (!wr) [*2] |-> pos_source_select_zero == route($past(pwdata[10:9], 2)))
    else $error("positive source not routed");

  a_raw_set: assert property (
    int_ev[0] |=> raw[0])
    else $error("raw status not set by event");

  a_w1c_clear: assert property (
    s_clr0 |=> !raw[0] && !irq || (raw[1] && inten[1]))
    else $error("write one did not clear status");

  a_enable_gate: assert property (
    (inten == 2'h0) |-> !irq ##0 (raw == 2'h0 || !irq))
    else $error("disabled event reached the interrupt");

  a_status_read: assert property (
    setup && !pwrite && paddr == DCC_OFS_STAT0 |=> prdata[1] == $past(value[0]) && prdata[0] == 1'b0)
    else $error("status read does not show output value");

  a_pin_gate: assert property (
    !ctl[0][DCC_CTL_TOEN] |=> !cmp_zero_out_pin)
    else $error("pin output without enable");

  a_trig_pulse: assert property (
    trig_ev[1] |=> adc_trigger[1])
    else $error("trigger not forwarded");

endmodule : dcc_core

// *** verif/dcc_analog_model.sv ***
// behavioural model of the analog comparator pair in front of the control block
`timescale 1ns/1ns
module dcc_analog_model
  import dcc_pkg::*;
#(
  parameter int AVDD_MV = 3300
) (
  input  wire logic [11:0] pos_zero_mv,
  input  wire logic [11:0] pos_one_mv,
  input  wire logic [11:0] neg_zero_mv,
  input  wire logic [11:0] neg_one_mv,
  input  wire logic [1:0]  src_zero,
  input  wire logic [1:0]  src_one,
  input  wire logic [4:0]  ref_num,
  input  wire logic [4:0]  ref_den,
  output logic [1:0]       result
);
  int ref_mv;

  // ---------------------------------------------------------------
  // ladder voltage
  // ---------------------------------------------------------------
  // ladder tap voltage
  assign ref_mv = (ref_den == 5'h00) ? 0 : AVDD_MV * int'(ref_num) / int'(ref_den);

  function automatic int pick(input logic [1:0] s, input int own, input int zero, input int vref);
    case (s)
      2'h1: return zero;
      2'h2: return vref;
      default: return own;
    endcase
  endfunction : pick

  // ---------------------------------------------------------------
  // comparison
  // ---------------------------------------------------------------
  // routed compare
  always_comb begin
    result[0] = int'(neg_zero_mv) < pick(src_zero, int'(pos_zero_mv), int'(pos_zero_mv), ref_mv);
    result[1] = int'(neg_one_mv) < pick(src_one, int'(pos_one_mv), int'(pos_zero_mv), ref_mv);
  end
endmodule : dcc_analog_model

// *** verif/dcc_core_tb.sv ***
// self-checking testbench for the dual comparator control block
`timescale 1ns/1ns
module dcc_core_tb;
  import dcc_pkg::*;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        ladder_enable, ladder_range, cmp_zero_out_pin, irq;
  logic [11:0] paddr, p0_mv, p1_mv, n0_mv, n1_mv;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0]  cres, src0, src1, adc_trigger;
  logic [3:0]  ladder_tap;
  logic [4:0]  ref_num, ref_den;
  logic [32:0] exp_q[$];
  logic [11:0] offs[8] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h020, 12'h024, 12'h040, 12'h044};
  logic [9:0]  rctl[3] = '{10'h30c, 10'h20c, 10'h10c};
  int          fails, n_compared, c, pos, s;

  dcc_core dcc_core_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .comparison_result(cres),
    .pos_source_select_zero(src0), .pos_source_select_one(src1), .ladder_enable(ladder_enable),
    .ladder_range(ladder_range), .ladder_tap(ladder_tap), .ref_numerator(ref_num), .ref_denominator(ref_den),
    .cmp_zero_out_pin(cmp_zero_out_pin), .adc_trigger(adc_trigger), .irq(irq));

  dcc_analog_model dcc_analog_model_inst (
    .pos_zero_mv(p0_mv), .pos_one_mv(p1_mv), .neg_zero_mv(n0_mv), .neg_one_mv(n1_mv), .src_zero(src0),
    .src_one(src1), .ref_num(ref_num), .ref_den(ref_den), .result(cres));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // entered just after a rising edge; leaves one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stuck transfer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle();
    c = 0;
    repeat (8) begin
      @(posedge clk_sys);
      if (adc_trigger[0] === 1'b1) c++;
    end
  endtask : settle

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  function automatic int refmv(input logic [9:0] r);
    if (!r[9]) return 0;
    return r[8] ? 3300 * int'(r[3:0]) / 23 : 3300 * (int'(r[3:0]) + 8) / 31;
  endfunction : refmv

  // read results are compared against the oldest note when they appear
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1, "unexpected read");
      else chk({pslverr, prdata}, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    close_out();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000; pwdata = 32'h0; p0_mv = 12'h000; p1_mv = 12'h000; n0_mv = 12'h000; n1_mv = 12'h000;
    rst_n = 1'b0; seed = 32'h7f209fce; fails = 0; n_compared = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // level sense at reset: low output matches level zero, so raw fills at once
    foreach (offs[i]) rd(offs[i], (offs[i] == DCC_OFS_RIS) ? 33'h3 : 33'h0);
    rd(12'h00c, 33'h100000000);
    wr(DCC_OFS_RIS, 32'h3);
    rd(DCC_OFS_RIS, 33'h3);
    $display("test reset done");

    foreach (rctl[i]) begin
      wr(DCC_OFS_REFCTL, {22'h0, rctl[i]});
      repeat (3) @(posedge clk_sys);
      chk(33'({ladder_enable, ladder_range, ladder_tap, ref_num, ref_den}), 33'({rctl[i][9], rctl[i][8],
          rctl[i][3:0], rctl[i][9] ? (rctl[i][8] ? {1'b0, rctl[i][3:0]} : 5'({1'b0, rctl[i][3:0]} + 5'h08)) : 5'h00,
          rctl[i][8] ? 5'h17 : 5'h1f}), "ladder outputs");
      rd(DCC_OFS_REFCTL, {23'h0, rctl[i]});
    end
    $display("test reference done");

    // control written before any result is trusted
    wr(DCC_OFS_REFCTL, 32'h30c);
    wr(DCC_OFS_CTL0, 32'hc28);
    wr(DCC_OFS_INTEN, 32'h1);
    n0_mv <= 12'd3000;
    settle();
    wr(DCC_OFS_MIS, 32'h3);
    n0_mv <= 12'd500;
    settle();
    chk(33'(c), 33'h0, "no trigger on rise");
    chk(33'({irq, cmp_zero_out_pin}), 33'h3, "irq and pin");
    rd(DCC_OFS_RIS, 33'h3);
    rd(DCC_OFS_MIS, 33'h1);
    rd(DCC_OFS_STAT0, 33'h2);
    wr(DCC_OFS_MIS, 32'h0);
    rd(DCC_OFS_MIS, 33'h1);
    wr(DCC_OFS_MIS, 32'h1);
    rd(DCC_OFS_RIS, 33'h2);
    chk(33'(irq), 33'h0, "irq after clear");
    n0_mv <= 12'd3000;
    settle();
    chk(33'(c), 33'h1, "one trigger on fall");
    chk(33'({irq, cmp_zero_out_pin}), 33'h0, "no irq on fall");
    $display("test events done");

    wr(DCC_OFS_CTL1, 32'h0c);
    p1_mv <= 12'd2000;
    n1_mv <= 12'd1000;
    settle();
    rd(DCC_OFS_RIS, 33'h2);
    rd(DCC_OFS_MIS, 33'h0);
    chk(33'(irq), 33'h0, "masked irq");
    chk(33'(adc_trigger), 33'h0, "no trigger while level unmet");
    wr(DCC_OFS_INTEN, 32'h3);
    chk(33'(irq), 33'h1, "unmasked irq");
    wr(DCC_OFS_MIS, 32'h2);
    chk(33'(irq), 33'h0, "irq cleared");
    $display("test masking done");

    for (int i = 0; i < 12; i++) begin
      s = (i % 4 == 3) ? 2 : i % 4;
      wr(DCC_OFS_REFCTL, (i % 4 == 3) ? 32'h10c : 32'h30c);
      seed = xs(seed);
      p0_mv <= seed[11:0];
      p1_mv <= seed[23:12];
      pos = (s == 0) ? int'(seed[23:12]) : (s == 1) ? int'(seed[11:0]) : refmv((i % 4 == 3) ? 10'h10c : 10'h30c);
      seed = xs(seed);
      n1_mv <= (int'(seed[11:0]) == pos) ? (seed[11:0] ^ 12'h001) : seed[11:0];
      wr(DCC_OFS_CTL1, {21'h0, 2'(s), 9'h0});
      repeat (5) @(posedge clk_sys);
      rd(DCC_OFS_STAT1, {31'h0, int'(n1_mv) < pos, 1'b0});
    end
    $display("test sources done");
    close_out();
  end
endmodule : dcc_core_tb
